/* File: verilog/timer_channel_mode_config.sv */
// Purpose: APB register file and two capture/compare channel configurations
// Assumes: Counter and update event come from the timer core
// Notes: Zero-wait APB; polarity and flags live elsewhere
// ****************************************
// ****************************************
//
// Register access over APB is this design's own decision.
`include "timer_ccm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_config #(
    parameter int CNT_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [CNT_W-1:0] counter_i,
    input wire logic update_evt_i,
    input wire logic pin_input_one_i,
    input wire logic pin_input_two_i,
    input wire logic internal_trigger_src_i,
    output logic [1:0] channel_ref_out_o,
    output logic [1:0] capture_evt_o
);
    logic [`CFG_WIDTH-1:0] channel1_mode_config;
    logic [`CFG_WIDTH-1:0] channel2_mode_config;
    logic [1:0] channel_capcomp_en;
    logic [1:0] prot_level;
    logic [15:0] ccr1_buf;
    logic [15:0] ccr2_buf;
    logic [31:0] prdata_q;
    logic [31:0] next_rdata;
    logic wr_en;
    logic mapped;
    logic locked;
    logic [`CFG_WIDTH-1:0] next_cfg1;
    logic [`CFG_WIDTH-1:0] next_cfg2;

    chan_if ch1_bus ();
    chan_if ch2_bus ();

    // ****************************************
    // APB slave
    // ****************************************
    // Read data is caught in the setup cycle so it can leave a flop
    assign mapped = (paddr_i == `OFF_CTRL) || (paddr_i == `OFF_CCR1) ||
        (paddr_i == `OFF_CCR2) || (paddr_i == `OFF_STAT) ||
        (paddr_i == `OFF_CH1) || (paddr_i == `OFF_CH2);
    assign wr_en = psel_i && penable_i && pwrite_i && mapped;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata_q;
    assign locked = (prot_level == `PROT_LOCKED);

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr_i)
            `OFF_CTRL: begin
                next_rdata[`CTRL_EN1] = channel_capcomp_en[0];
                next_rdata[`CTRL_EN2] = channel_capcomp_en[1];
                next_rdata[`CTRL_PROT_HI:`CTRL_PROT_LO] = prot_level;
            end
            `OFF_CCR1: next_rdata[15:0] = ch1_bus.ccr_active;
            `OFF_CCR2: next_rdata[15:0] = ch2_bus.ccr_active;
            `OFF_STAT: next_rdata[3:0] = {ch2_bus.filt_level, ch1_bus.filt_level,
                channel_ref_out_o};
            `OFF_CH1: next_rdata[`CFG_WIDTH-1:0] = channel1_mode_config;
            `OFF_CH2: next_rdata[`CFG_WIDTH-1:0] = channel2_mode_config;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_q <= next_rdata;
        end
    end

    // ****************************************
    // Control and compare registers
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            channel_capcomp_en <= 2'h0;
            prot_level <= 2'h0;
        end else if (wr_en && paddr_i == `OFF_CTRL) begin
            channel_capcomp_en <= {pwdata_i[`CTRL_EN2], pwdata_i[`CTRL_EN1]};
            prot_level <= pwdata_i[`CTRL_PROT_HI:`CTRL_PROT_LO];
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ccr1_buf <= 16'h0000;
            ccr2_buf <= 16'h0000;
        end else begin
            if (wr_en && paddr_i == `OFF_CCR1) ccr1_buf <= pwdata_i[15:0];
            if (wr_en && paddr_i == `OFF_CCR2) ccr2_buf <= pwdata_i[15:0];
        end
    end

    // ****************************************
    // Mode registers
    // ****************************************
    // Lock covers preload and mode bits, which share positions with input fields
    function automatic logic [`CFG_WIDTH-1:0] merge_cfg(input logic [`CFG_WIDTH-1:0] old,
        input logic [31:0] wd, input logic en, input logic lk);
        logic [`CFG_WIDTH-1:0] res;
        res = wd[`CFG_WIDTH-1:0];
        if (en) begin
            res[`DIR_HI:`DIR_LO] = old[`DIR_HI:`DIR_LO];
        end
        // Lock passed in so the continuous assign below sees its changes
        if (lk && old[`DIR_HI:`DIR_LO] == `DIR_OUT) begin
            res[`MODE_HI:`PRE_BIT] = old[`MODE_HI:`PRE_BIT];
        end
        merge_cfg = res;
    endfunction : merge_cfg

    assign next_cfg1 = merge_cfg(channel1_mode_config, pwdata_i, channel_capcomp_en[0], locked);
    assign next_cfg2 = merge_cfg(channel2_mode_config, pwdata_i, channel_capcomp_en[1], locked);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            channel1_mode_config <= '0;
            channel2_mode_config <= '0;
        end else begin
            if (wr_en && paddr_i == `OFF_CH1) channel1_mode_config <= next_cfg1;
            if (wr_en && paddr_i == `OFF_CH2) channel2_mode_config <= next_cfg2;
        end
    end

    // ****************************************
    // Channel hookup
    // ****************************************
    assign ch1_bus.dir = channel1_mode_config[`DIR_HI:`DIR_LO];
    assign ch1_bus.preload_en = channel1_mode_config[`PRE_BIT];
    assign ch1_bus.mode = channel1_mode_config[`MODE_HI:`MODE_LO];
    assign ch1_bus.prescale_factor = channel1_mode_config[`PSC_HI:`PSC_LO];
    assign ch1_bus.filt = channel1_mode_config[`FILT_HI:`FILT_LO];
    assign ch1_bus.enable = channel_capcomp_en[0];
    assign ch1_bus.src_valid = 1'b1;
    // Direct load takes the bus word, since the buffer only updates on this edge
    assign ch1_bus.ccr_wdata = ch1_bus.ccr_wr ? pwdata_i[15:0] : ccr1_buf;
    assign ch1_bus.ccr_wr = wr_en && paddr_i == `OFF_CCR1;
    assign ch1_bus.update_evt = update_evt_i;
    assign ch1_bus.counter = 16'(counter_i);

    always_comb begin
        case (ch1_bus.dir)
            `DIR_OWN: ch1_bus.src_in = pin_input_one_i;
            `DIR_NEIGH: ch1_bus.src_in = pin_input_two_i;
            `DIR_TRIG: ch1_bus.src_in = internal_trigger_src_i;
            default: ch1_bus.src_in = 1'b0;
        endcase
    end

    assign ch2_bus.dir = channel2_mode_config[`DIR_HI:`DIR_LO];
    assign ch2_bus.preload_en = channel2_mode_config[`PRE_BIT];
    assign ch2_bus.mode = channel2_mode_config[`MODE_HI:`MODE_LO];
    assign ch2_bus.prescale_factor = channel2_mode_config[`PSC_HI:`PSC_LO];
    assign ch2_bus.filt = channel2_mode_config[`FILT_HI:`FILT_LO];
    assign ch2_bus.enable = channel_capcomp_en[1];
    assign ch2_bus.src_valid = (ch2_bus.dir != `DIR_TRIG);
    assign ch2_bus.ccr_wdata = ch2_bus.ccr_wr ? pwdata_i[15:0] : ccr2_buf;
    assign ch2_bus.ccr_wr = wr_en && paddr_i == `OFF_CCR2;
    assign ch2_bus.update_evt = update_evt_i;
    assign ch2_bus.counter = 16'(counter_i);

    always_comb begin
        case (ch2_bus.dir)
            `DIR_OWN: ch2_bus.src_in = pin_input_two_i;
            `DIR_NEIGH: ch2_bus.src_in = pin_input_one_i;
            default: ch2_bus.src_in = 1'b0;
        endcase
    end

    ccm_channel u_ch1 (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ch(ch1_bus.chan)
    );

    ccm_channel u_ch2 (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ch(ch2_bus.chan)
    );

    assign channel_ref_out_o = {ch2_bus.ref_out, ch1_bus.ref_out};
    assign capture_evt_o = {ch2_bus.capture, ch1_bus.capture};

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    property p_lock;
        wr_en && paddr_i == `OFF_CH1 && locked &&
            channel1_mode_config[`DIR_HI:`DIR_LO] == `DIR_OUT
        |=> $stable(channel1_mode_config[`MODE_HI:`PRE_BIT]);
    endproperty
    a_lock: assert property (p_lock) else $error("locked mode field changed");
    property p_dir;
        wr_en && paddr_i == `OFF_CH2 && channel_capcomp_en[1]
        |=> $stable(channel2_mode_config[`DIR_HI:`DIR_LO]);
    endproperty
    a_dir: assert property (p_dir) else $error("direction changed while enabled");
    c_lock_write: cover property (wr_en && paddr_i == `OFF_CH1 && locked);
endmodule : timer_channel_mode_config
`default_nettype wire

/* File: pkg/timer_ccm_defs.svh */
// Purpose: Offsets, field positions and codes of the channel mode block
// Assumes: Byte addresses on an 8-bit APB address
// Notes: Definitions only
`ifndef TIMER_CCM_DEFS_SVH
`define TIMER_CCM_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFF_CTRL 8'h00
`define OFF_CCR1 8'h04
`define OFF_CCR2 8'h08
`define OFF_STAT 8'h0c
`define OFF_CH1 8'h1c
`define OFF_CH2 8'h20
// ****************************************
// Field positions and values
// ****************************************
`define CTRL_EN1 0
`define CTRL_EN2 1
`define CTRL_PROT_LO 8
`define CTRL_PROT_HI 9
`define PROT_LOCKED 2'h3
`define CFG_WIDTH 8
`define DIR_HI 1
`define DIR_LO 0
`define PRE_BIT 3
`define MODE_HI 6
`define MODE_LO 4
`define PSC_HI 3
`define PSC_LO 2
`define FILT_HI 7
`define FILT_LO 4
`define DIR_OUT 2'h0
`define DIR_OWN 2'h1
`define DIR_NEIGH 2'h2
`define DIR_TRIG 2'h3
`define CM_FROZEN 3'h0
`define CM_SET 3'h1
`define CM_CLR 3'h2
`define CM_TOG 3'h3
`define CM_LOW 3'h4
`define CM_HIGH 3'h5
`define CM_PWM1 3'h6
`define CM_PWM2 3'h7
`define FILT_OFF 4'h0
`endif

/* File: pkg/timer_ccm_pkg.sv */
// Purpose: Types of the channel mode block
// Assumes: Nothing
// Notes: Filter table lives here
package timer_ccm_pkg;
    typedef logic [2:0] cmp_mode_t;
    typedef logic [1:0] dir_t;
    typedef logic [5:0] fdiv_t;
    typedef logic [3:0] flen_t;

    // Divider and sample count per filter code
    function automatic fdiv_t filt_div(input logic [3:0] code);
        case (code)
            4'h1, 4'h2, 4'h3: filt_div = 6'h01;
            4'h4, 4'h5: filt_div = 6'h02;
            4'h6, 4'h7: filt_div = 6'h04;
            4'h8, 4'h9: filt_div = 6'h08;
            4'ha, 4'hb, 4'hc: filt_div = 6'h10;
            4'hd, 4'he, 4'hf: filt_div = 6'h20;
            default: filt_div = 6'h01;
        endcase
    endfunction : filt_div

    function automatic flen_t filt_len(input logic [3:0] code);
        case (code)
            4'h1: filt_len = 4'h2;
            4'h2: filt_len = 4'h4;
            4'h4, 4'h6, 4'h8, 4'hb, 4'he: filt_len = 4'h6;
            4'ha, 4'hd: filt_len = 4'h5;
            default: filt_len = 4'h8;
        endcase
    endfunction : filt_len
endpackage : timer_ccm_pkg

/* File: pkg/chan_if.sv */
// Purpose: Carrier between register file and one channel
// Assumes: One clock
// Notes: Config in, status out
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
    timer_ccm_pkg::dir_t dir;
    logic preload_en;
    timer_ccm_pkg::cmp_mode_t mode;
    logic [1:0] prescale_factor;
    logic [3:0] filt;
    logic enable;
    logic src_in;
    logic src_valid;
    logic [15:0] ccr_wdata;
    logic ccr_wr;
    logic update_evt;
    logic [15:0] counter;
    logic ref_out;
    logic capture;
    logic filt_level;
    logic [15:0] ccr_active;
    modport regs (output dir, preload_en, mode, prescale_factor, filt, enable, src_in, src_valid,
        ccr_wdata, ccr_wr, update_evt, counter,
        input ref_out, capture, filt_level, ccr_active);
    modport chan (input dir, preload_en, mode, prescale_factor, filt, enable, src_in, src_valid,
        ccr_wdata, ccr_wr, update_evt, counter,
        output ref_out, capture, filt_level, ccr_active);
endinterface : chan_if
`default_nettype wire

/* File: verilog/ccm_channel.sv */
// Purpose: One capture/compare channel: reference waveform, filter, prescaler
// Assumes: Counter value supplied from outside
// Notes: Capture fires on rising edge of filtered input
`include "timer_ccm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ccm_channel (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    chan_if.chan ch
);
    logic ref_q;
    logic [15:0] ccr;
    logic [5:0] div_cnt;
    logic [3:0] run_cnt;
    logic filt_q;
    logic filt_prev;
    logic [2:0] ev_cnt;
    logic [1:0] psc_prev;
    logic cap_q;
    logic is_out;
    logic match;
    logic tick;
    logic rise;
    logic [2:0] ev_need;

    assign is_out = (ch.dir == `DIR_OUT);
    assign match = (ch.counter == ccr);
    assign ch.ref_out = ref_q;
    assign ch.ccr_active = ccr;
    assign ch.filt_level = filt_q;
    assign ch.capture = cap_q;

    // ****************************************
    // Compare value
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ccr <= 16'h0000;
        end else if (ch.ccr_wr && !ch.preload_en) begin
            ccr <= ch.ccr_wdata;
        end else if (ch.update_evt && ch.preload_en) begin
            ccr <= ch.ccr_wdata;
        end
    end

    // ****************************************
    // Reference output
    // ****************************************
    // PWM is re-evaluated every cycle, so leaving frozen takes effect at once
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ref_q <= 1'b0;
        end else if (is_out) begin
            case (ch.mode)
                `CM_FROZEN: ref_q <= ref_q;
                `CM_SET: if (match) ref_q <= 1'b1;
                `CM_CLR: if (match) ref_q <= 1'b0;
                `CM_TOG: if (match) ref_q <= !ref_q;
                `CM_LOW: ref_q <= 1'b0;
                `CM_HIGH: ref_q <= 1'b1;
                `CM_PWM1: ref_q <= (ch.counter < ccr);
                `CM_PWM2: ref_q <= (ch.counter > ccr);
                default: ref_q <= ref_q;
            endcase
        end
    end

    // ****************************************
    // Input filter
    // ****************************************
    assign tick = (div_cnt >= timer_ccm_pkg::filt_div(ch.filt) - 6'h01);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_cnt <= 6'h00;
        end else if (tick) begin
            div_cnt <= 6'h00;
        end else begin
            div_cnt <= div_cnt + 6'h01;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            filt_q <= 1'b0;
            run_cnt <= 4'h0;
        end else if (ch.filt == `FILT_OFF) begin
            filt_q <= ch.src_in;
            run_cnt <= 4'h0;
        end else if (tick) begin
            if (ch.src_in == filt_q) begin
                run_cnt <= 4'h0;
            end else if (run_cnt + 4'h1 >= timer_ccm_pkg::filt_len(ch.filt)) begin
                filt_q <= ch.src_in;
                run_cnt <= 4'h0;
            end else begin
                run_cnt <= run_cnt + 4'h1;
            end
        end
    end

    // ****************************************
    // Capture prescaler
    // ****************************************
    assign rise = filt_q && !filt_prev && ch.src_valid && !is_out;
    assign ev_need = 3'((4'h1 << ch.prescale_factor) - 4'h1);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            filt_prev <= 1'b0;
            psc_prev <= 2'h0;
        end else begin
            filt_prev <= filt_q;
            psc_prev <= ch.prescale_factor;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ev_cnt <= 3'h0;
            cap_q <= 1'b0;
        end else if (!ch.enable || ch.prescale_factor != psc_prev) begin
            ev_cnt <= 3'h0;
            cap_q <= 1'b0;
        end else if (rise) begin
            cap_q <= (ev_cnt == ev_need);
            ev_cnt <= (ev_cnt == ev_need) ? 3'h0 : ev_cnt + 3'h1;
        end else begin
            cap_q <= 1'b0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    property p_set;
        is_out && ch.mode == `CM_SET && match |=> ref_q;
    endproperty
    a_set: assert property (p_set) else $error("set on match failed");
    property p_clr;
        is_out && ch.mode == `CM_CLR && match |=> !ref_q;
    endproperty
    a_clr: assert property (p_clr) else $error("clear on match failed");
    property p_tog;
        is_out && ch.mode == `CM_TOG && match |=> ref_q != $past(ref_q);
    endproperty
    a_tog: assert property (p_tog) else $error("toggle on match failed");
    property p_frozen;
        is_out && ch.mode == `CM_FROZEN |=> $stable(ref_q);
    endproperty
    a_frozen: assert property (p_frozen) else $error("frozen output moved");
    property p_force;
        is_out && ch.mode == `CM_LOW ##1 is_out && ch.mode == `CM_HIGH |-> !ref_q ##1 ref_q;
    endproperty
    a_force: assert property (p_force) else $error("forced level wrong");
    property p_pwm1;
        is_out && ch.mode == `CM_PWM1 |=> ref_q == ($past(ch.counter) < $past(ccr));
    endproperty
    a_pwm1: assert property (p_pwm1) else $error("pwm style one wrong");
    property p_pwm2;
        is_out && ch.mode == `CM_PWM2 |=> ref_q == ($past(ch.counter) > $past(ccr));
    endproperty
    a_pwm2: assert property (p_pwm2) else $error("pwm style two wrong");
    property p_nocap;
        !ch.enable |=> !cap_q;
    endproperty
    a_nocap: assert property (p_nocap) else $error("capture while disabled");
    c_toggle: cover property (is_out && ch.mode == `CM_TOG && match);
    c_capture: cover property (cap_q && ch.prescale_factor == 2'h3);
    c_freeze_to_pwm: cover property (ch.mode == `CM_FROZEN ##1 ch.mode == `CM_PWM1);
endmodule : ccm_channel
`default_nettype wire

/* File: dv/src_model.sv */
// Purpose: Far side model: two timer input pins and the internal trigger
// Assumes: Caller enters right after a rising clock edge
// Notes: Lines idle low; every pulse ends with a stable low gap
`timescale 1ns/1ps
`default_nettype none
module src_model (
    input wire logic clk_i,
    output logic [2:0] src_o
);
    initial src_o = 3'h0;
    // Whole pulse plus gap, so the filter sees both edges settle
    task automatic pulse(input int sel, input int hi, input int lo);
        src_o[sel] <= 1'b1;
        repeat (hi) @(posedge clk_i);
        src_o[sel] <= 1'b0;
        repeat (lo) @(posedge clk_i);
    endtask : pulse
endmodule : src_model
`default_nettype wire

/* File: dv/timer_channel_mode_config_tb.sv */
// Purpose: Self-checking bench of the channel mode block
// Assumes: Zero-wait APB slave, capture on rising filtered edge
// Notes: Every scenario judges its own results
`include "timer_ccm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_config_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic upd = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic [15:0] cnt = 16'h0010;
    logic [2:0] src;
    logic [1:0] ref_o, cap;
    int failures = 0;
    int checks = 0;
    int caps [2] = '{0, 0};
    int div_tab [15] = '{1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
    int len_tab [15] = '{2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
    timer_channel_mode_config #(.CNT_W(16)) dut_u (.clk_sys_i(clk), .sys_rst_i(rst),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .counter_i(cnt),
        .update_evt_i(upd), .pin_input_one_i(src[0]), .pin_input_two_i(src[1]),
        .internal_trigger_src_i(src[2]), .channel_ref_out_o(ref_o), .capture_evt_o(cap));
    src_model src_u (.clk_i(clk), .src_o(src));
    initial forever #2.5 clk = ~clk;
    // Counted off the active edge to avoid racing the pulse flops
    always @(negedge clk) begin
        if (cap[0] === 1'b1) caps[0]++;
        if (cap[1] === 1'b1) caps[1]++;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(32'h0000_0000, 32'h0000_0001, "apb timeout");
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp, msg);
    endtask : rdchk
    function automatic logic [31:0] mcfg(input logic [1:0] d, input logic p, input logic [2:0] m);
        return {25'h0, m, p, 1'b0, d};
    endfunction : mcfg
    function automatic logic [31:0] icfg(input logic [1:0] d, input logic [1:0] s, input logic [3:0] f);
        return {24'h0, f, s, d};
    endfunction : icfg
    task automatic settle(input int ch, input logic [15:0] c, input logic e, input string msg);
        cnt <= c;
        repeat (3) @(posedge clk);
        chk(ref_o[ch], e, msg);
    endtask : settle
    // One match cycle only, so toggle mode flips exactly once
    task automatic hit(input int ch, input logic e, input string msg);
        cnt <= 16'h0040;
        @(posedge clk);
        settle(ch, 16'h0041, e, msg);
    endtask : hit
    task automatic arm(input int ch, input logic [31:0] cfg);
        wr(`OFF_CTRL, 32'h0000_0000);
        wr(ch ? `OFF_CH2 : `OFF_CH1, cfg);
        wr(`OFF_CTRL, ch ? 32'h0000_0002 : 32'h0000_0001);
        caps = '{0, 0};
    endtask : arm
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rdchk(`OFF_CH1, 32'h0000_0000, "ch1 reset");
        rdchk(`OFF_CH2, 32'h0000_0000, "ch2 reset");
        apb(1'b0, 8'hfc, 32'h0000_0000);
        chk(err, 1'b1, "unmapped error");
        wr(`OFF_CH2, 32'hffff_ffff);
        rdchk(`OFF_CH2, 32'h0000_00ff, "reserved bits");
        wr(`OFF_CH2, 32'h0000_0000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_compare(input int ch);
        logic [7:0] ma;
        ma = ch ? `OFF_CH2 : `OFF_CH1;
        wr(ch ? `OFF_CCR2 : `OFF_CCR1, 32'h0000_0040);
        wr(ma, mcfg(`DIR_OUT, 1'b0, `CM_HIGH));
        settle(ch, 16'h0010, 1'b1, "force high");
        wr(ma, mcfg(`DIR_OUT, 1'b0, `CM_FROZEN));
        hit(ch, 1'b1, "frozen match");
        wr(ma, mcfg(`DIR_OUT, 1'b0, `CM_CLR));
        hit(ch, 1'b0, "clear on match");
        wr(ma, mcfg(`DIR_OUT, 1'b0, `CM_SET));
        hit(ch, 1'b1, "set on match");
        wr(ma, mcfg(`DIR_OUT, 1'b0, `CM_TOG));
        hit(ch, 1'b0, "toggle one");
        hit(ch, 1'b1, "toggle two");
        wr(ma, mcfg(`DIR_OUT, 1'b0, `CM_LOW));
        settle(ch, 16'h0040, 1'b0, "force low");
        wr(ma, mcfg(`DIR_OUT, 1'b0, `CM_FROZEN));
        settle(ch, 16'h0010, 1'b0, "frozen hold");
        wr(ma, mcfg(`DIR_OUT, 1'b0, `CM_PWM1));
        settle(ch, 16'h0010, 1'b1, "frozen to pwm");
        settle(ch, 16'h0040, 1'b0, "pwm1 equal");
        settle(ch, 16'h003f, 1'b1, "pwm1 below");
        wr(ma, mcfg(`DIR_OUT, 1'b0, `CM_PWM2));
        settle(ch, 16'h0041, 1'b1, "pwm2 above");
        settle(ch, 16'h0040, 1'b0, "pwm2 equal");
        $display("test compare ch%0d done", ch + 1);
    endtask : t_compare
    task automatic t_preload();
        wr(`OFF_CH1, mcfg(`DIR_OUT, 1'b0, `CM_FROZEN));
        wr(`OFF_CCR1, 32'h0000_0123);
        rdchk(`OFF_CCR1, 32'h0000_0123, "direct load");
        wr(`OFF_CH1, mcfg(`DIR_OUT, 1'b1, `CM_FROZEN));
        wr(`OFF_CCR1, 32'h0000_0456);
        rdchk(`OFF_CCR1, 32'h0000_0123, "held until update");
        upd <= 1'b1;
        @(posedge clk);
        upd <= 1'b0;
        @(posedge clk);
        rdchk(`OFF_CCR1, 32'h0000_0456, "loaded at update");
        $display("test preload done");
    endtask : t_preload
    task automatic t_lock();
        wr(`OFF_CH1, mcfg(`DIR_OUT, 1'b0, `CM_HIGH));
        wr(`OFF_CTRL, 32'h0000_0300);
        wr(`OFF_CH1, mcfg(`DIR_OUT, 1'b1, `CM_LOW));
        rdchk(`OFF_CH1, mcfg(`DIR_OUT, 1'b0, `CM_HIGH), "locked mode");
        chk(ref_o[0], 1'b1, "locked output");
        wr(`OFF_CTRL, 32'h0000_0001);
        wr(`OFF_CH1, 32'h0000_0001);
        rdchk(`OFF_CH1, 32'h0000_0000, "direction gated");
        wr(`OFF_CTRL, 32'h0000_0000);
        $display("test lock done");
    endtask : t_lock
    // Each row: channel, direction, selected source, a source that must be ignored
    task automatic t_capture();
        int rch [6] = '{0, 0, 0, 1, 1, 1};
        int rdir [6] = '{1, 2, 3, 1, 2, 3};
        int good [6] = '{0, 1, 2, 1, 0, -1};
        int bad [6] = '{1, 0, 0, 0, 1, 0};
        for (int r = 0; r < 6; r++) begin
            for (int s = 0; s < 4; s++) begin
                arm(rch[r], icfg(rdir[r][1:0], s[1:0], `FILT_OFF));
                for (int k = 0; k < 8; k++) begin
                    if (good[r] >= 0) src_u.pulse(good[r], 4, 4);
                    src_u.pulse(bad[r], 4, 4);
                end
                chk(caps[rch[r]], good[r] < 0 ? 0 : 8 >> s, "capture count");
            end
        end
        arm(0, icfg(`DIR_OWN, 2'h1, `FILT_OFF));
        src_u.pulse(0, 4, 4);
        wr(`OFF_CTRL, 32'h0000_0000);
        wr(`OFF_CTRL, 32'h0000_0001);
        src_u.pulse(0, 4, 4);
        chk(caps[0], 0, "count restarted");
        src_u.pulse(0, 4, 4);
        chk(caps[0], 1, "count after restart");
        $display("test capture done");
    endtask : t_capture
    // Short pulse spans one tick fewer than the length, long one enough
    task automatic t_filter();
        int d, n;
        arm(0, icfg(`DIR_OWN, 2'h0, `FILT_OFF));
        src_u.pulse(0, 1, 8);
        chk(caps[0], 1, "unfiltered pulse");
        for (int c = 1; c < 16; c++) begin
            d = div_tab[c - 1];
            n = len_tab[c - 1];
            arm(0, icfg(`DIR_OWN, 2'h0, c[3:0]));
            src_u.pulse(0, d * (n - 1), d * (n + 2) + 4);
            chk(caps[0], 0, "short pulse");
            src_u.pulse(0, d * (n + 1), d * (n + 2) + 4);
            chk(caps[0], 1, "long pulse");
        end
        $display("test filter done");
    endtask : t_filter
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_compare(0);
        t_compare(1);
        t_preload();
        t_lock();
        t_capture();
        t_filter();
        tally_and_finish();
    end
endmodule : timer_channel_mode_config_tb
`default_nettype wire
